/* File: bench/tsr_conv_model.sv */
// Behavioural converter model answering the core's start pulses
`timescale 1ns/1ps
`default_nettype none
module tsr_conv_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic [11:0] temp_i,
    input  wire logic [7:0]  lat_i,
    output var  logic        done_o,
    output var  logic [11:0] result_o
);
    integer cnt;
    // Latency set per conversion, so answers come both promptly and slowly
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_o   <= 1'b0;
            result_o <= 12'h000;
            cnt      <= -1;
        end else begin
            done_o   <= 1'b0;
            result_o <= ~result_o; // Result is not held outside the done cycle
            if (start_i) begin
                cnt <= lat_i;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end else if (cnt == 0) begin
                done_o   <= 1'b1;
                result_o <= temp_i;
                cnt      <= -1;
            end
        end
    end
endmodule // tsr_conv_model
`default_nettype wire

/* File: bench/tsr_core_checker.sv */
// Port-level assertions for the sensor register core
`timescale 1ns/1ps
`default_nettype none
module tsr_core_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        sel_wr_i,
    input wire logic [7:0]  sel_data_i,
    input wire logic        data_wr_i,
    input wire logic [7:0]  wr_data_i,
    input wire logic        rd_second_i,
    input wire logic [7:0]  rd_data_o,
    input wire logic        cfg_rd_done_i,
    input wire logic        conv_start_o,
    input wire logic        conv_done_i,
    input wire logic [11:0] conv_result_i,
    input wire logic        conv_busy_o,
    input wire logic        upper_flag_o,
    input wire logic        lower_flag_o
);
    logic [2:0] sel_q;
    logic [7:0] upr_q;
    logic [7:0] lwr_q;
    logic       lat_q;
    logic       gt_q;
    logic       lt_q;
    logic       fin;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    assign fin = conv_busy_o && conv_done_i;
    // Shadow of selector, thresholds, latch bit and signed compares
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_q <= 3'h0;
            upr_q <= 8'h3C;
            lwr_q <= 8'hF6;
            lat_q <= 1'b0;
            gt_q  <= 1'b0;
            lt_q  <= 1'b0;
        end else begin
            if (sel_wr_i) sel_q <= sel_data_i[2:0];
            if (data_wr_i && sel_q == 3'h3) upr_q <= wr_data_i;
            if (data_wr_i && sel_q == 3'h2) lwr_q <= wr_data_i;
            if (data_wr_i && sel_q == 3'h1) lat_q <= wr_data_i[2];
            gt_q <= $signed(conv_result_i[11:4]) > $signed(upr_q);
            lt_q <= $signed(conv_result_i[11:4]) < $signed(lwr_q);
        end
    end
    a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse longer than one cycle");
    a_busy_start: assert property (conv_start_o |-> conv_busy_o)
        else $error("start without busy");
    a_done_idle: assert property (fin |=> !conv_busy_o)
        else $error("busy stays after done");
    a_flags_hold: assert property (!fin && !cfg_rd_done_i |=>
        $stable(upper_flag_o) && $stable(lower_flag_o))
        else $error("flag moved without conversion or read");
    a_upper_cmp: assert property (fin && !lat_q && !data_wr_i |=> upper_flag_o == gt_q)
        else $error("upper flag wrong after conversion");
    a_lower_cmp: assert property (fin && !lat_q && !data_wr_i |=> lower_flag_o == lt_q)
        else $error("lower flag wrong after conversion");
    a_latch_hold: assert property (lat_q && fin && !data_wr_i && !cfg_rd_done_i
        && upper_flag_o |=> upper_flag_o)
        else $error("latched flag dropped");
    a_latch_clear: assert property (lat_q && cfg_rd_done_i && !fin && !data_wr_i
        |=> !upper_flag_o && !lower_flag_o)
        else $error("latched flags not cleared by read");
    a_lonib_zero: assert property (sel_q == 3'h0 && rd_second_i
        |=> rd_data_o[3:0] == 4'h0)
        else $error("low byte nibble not zero");
    a_unused_zero: assert property (sel_q > 3'h4 |=> rd_data_o == 8'h00)
        else $error("unused selector reads nonzero");
    a_thr_read: assert property (sel_q == 3'h3 && !data_wr_i |=> rd_data_o == upr_q)
        else $error("upper threshold read mismatch");
endmodule // tsr_core_checker
bind tsr_core tsr_core_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .sel_wr_i(sel_wr_i),
    .sel_data_i(sel_data_i), .data_wr_i(data_wr_i), .wr_data_i(wr_data_i),
    .rd_second_i(rd_second_i), .rd_data_o(rd_data_o), .cfg_rd_done_i(cfg_rd_done_i),
    .conv_start_o(conv_start_o), .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
    .conv_busy_o(conv_busy_o), .upper_flag_o(upper_flag_o), .lower_flag_o(lower_flag_o));
`default_nettype wire

/* File: bench/tsr_core_test.sv */
// Self-checking bench for the sensor register core
`timescale 1ns/1ps
`default_nettype none
module tsr_core_test;
    localparam int PER [4] = '{40, 20, 10, 8};
    logic        clk_i, rst_i, sel_wr_i, data_wr_i, rd_second_i, cfg_rd_done_i;
    logic        conv_start_o, conv_done_i, conv_busy_o, upper_flag_o, lower_flag_o;
    logic [7:0]  sel_data_i, wr_data_i, rd_data_o, lat_v, m_cfg, m_upr, m_lwr;
    logic [11:0] conv_result_i, temp_v, m_temp;
    logic        m_fh, m_fl;
    integer      num_errors, check_count, cyc, starts, t_start, t1, s0, i, r, seed_v;
    // Short periods keep the run small
    tsr_core #(.RATE_0P25HZ_CYC(32'h28), .RATE_1HZ_CYC(32'h14), .RATE_4HZ_CYC(32'h0A),
        .RATE_8HZ_CYC(32'h08)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .sel_wr_i(sel_wr_i),
        .sel_data_i(sel_data_i), .data_wr_i(data_wr_i), .wr_data_i(wr_data_i),
        .rd_second_i(rd_second_i), .rd_data_o(rd_data_o), .cfg_rd_done_i(cfg_rd_done_i),
        .conv_start_o(conv_start_o), .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
        .conv_busy_o(conv_busy_o), .upper_flag_o(upper_flag_o), .lower_flag_o(lower_flag_o));
    tsr_conv_model u_conv (.clk_i(clk_i), .rst_i(rst_i), .start_i(conv_start_o),
        .temp_i(temp_v), .lat_i(lat_v), .done_o(conv_done_i), .result_o(conv_result_i));
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Cycle count and start pulse log
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (conv_start_o === 1'b1) begin
            starts  <= starts + 1;
            t_start <= cyc;
        end
    end
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sel_wr_i   <= 1'b1;
        sel_data_i <= {5'h00, a};
        @(posedge clk_i);
        sel_wr_i  <= 1'b0;
        data_wr_i <= 1'b1;
        wr_data_i <= d;
        @(posedge clk_i);
        data_wr_i <= 1'b0;
    endtask
    // Read byte lags the selector by two edges
    task rd(input logic [2:0] a, input logic s, input logic [7:0] e);
        @(posedge clk_i);
        sel_wr_i    <= 1'b1;
        sel_data_i  <= {5'h00, a};
        rd_second_i <= s;
        @(posedge clk_i);
        sel_wr_i <= 1'b0;
        @(posedge clk_i);
        #1 chk("rd_data_o", e, rd_data_o);
    endtask
    task rd_cfg;
        rd(3'h1, 1'b0, {m_cfg[7:5], m_fh, m_fl, m_cfg[2:0]});
        @(posedge clk_i);
        cfg_rd_done_i <= 1'b1;
        @(posedge clk_i);
        cfg_rd_done_i <= 1'b0;
        if (m_cfg[2]) {m_fh, m_fl} = 2'b00;
    endtask
    task wait_idle;
        integer k;
        // Step off the edge so a busy launched on it is already visible
        #1;
        k = 0;
        while (conv_busy_o !== 1'b0 && k < 300) begin
            @(posedge clk_i) #1;
            k++;
        end
        if (k >= 300) begin
            num_errors++;
            complete_run;
        end
    endtask
    task wait_start;
        integer k, s;
        k = 0;
        s = starts;
        while (starts == s && k < 100) begin
            @(posedge clk_i) #1;
            k++;
        end
        if (k >= 100) begin
            num_errors++;
            complete_run;
        end
    endtask
    // Expected flags after a conversion of temp_v
    task model_conv;
        integer hi;
        hi = $signed(temp_v[11:4]);
        m_temp = temp_v;
        if (!m_cfg[2]) {m_fh, m_fl} = 2'b00;
        if (hi > $signed(m_upr)) m_fh = 1'b1;
        if (hi < $signed(m_lwr)) m_fl = 1'b1;
        chk("upper_flag_o", 8'(m_fh), 8'(upper_flag_o));
        chk("lower_flag_o", 8'(m_fl), 8'(lower_flag_o));
    endtask
    // Main sequence
    initial begin
        {sel_wr_i, data_wr_i, rd_second_i, cfg_rd_done_i} = 4'h0;
        sel_data_i = 8'h00;
        wr_data_i = 8'h00;
        {temp_v, lat_v} = {12'h5A3, 8'h1E};
        {num_errors, check_count, cyc, starts, t_start} = '0;
        {m_fh, m_fl, m_upr, m_lwr} = {2'b00, 8'h3C, 8'hF6};
        rst_i = 1'b1;
        seed_v = $urandom(32'hE28D14D8);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(3'h0, 1'b0, 8'h00);
        rd(3'h4, 1'b0, 8'h00);
        rd(3'h1, 1'b0, 8'h02);
        rd(3'h3, 1'b0, 8'h3C);
        rd(3'h2, 1'b0, 8'hF6);
        for (i = 5; i < 8; i++) rd(i[2:0], 1'b0, 8'h00);
        m_cfg = 8'h00;
        wr(3'h1, m_cfg);
        wait_idle;
        model_conv;
        s0 = starts;
        m_upr = 8'($urandom);
        m_lwr = 8'($urandom);
        wr(3'h3, m_upr);
        wr(3'h2, m_lwr);
        rd(3'h3, 1'b0, m_upr);
        rd(3'h2, 1'b0, m_lwr);
        repeat (60) @(posedge clk_i);
        chk("starts", 8'h00, 8'(starts - s0));
        // One-shot conversions with random results, latency and thresholds
        for (i = 0; i < 40; i++) begin
            temp_v <= 12'($urandom);
            lat_v <= 8'($urandom_range(0, 20));
            if (i % 8 == 0) begin
                m_upr = 8'($urandom);
                m_lwr = 8'($urandom);
                wr(3'h3, m_upr);
                wr(3'h2, m_lwr);
            end
            m_cfg = 8'($urandom);
            m_cfg[1:0] = 2'b01;
            s0 = starts;
            wr(3'h1, m_cfg);
            repeat (3) @(posedge clk_i);
            wait_idle;
            repeat (60) @(posedge clk_i);
            chk("starts", 8'h01, 8'(starts - s0));
            m_cfg[1:0] = 2'b00;
            model_conv;
            rd(3'h0, 1'b0, m_temp[11:4]);
            rd(3'h0, 1'b1, {m_temp[3:0], 4'h0});
            rd(3'h4, 1'b0, {m_temp[3:0], 4'h0});
            if ($urandom_range(0, 1)) rd_cfg;
        end
        // Continuous pacing at each rate, both continuous codes
        for (r = 0; r < 4; r++) begin
            lat_v <= 8'h02;
            wr(3'h1, 8'h00);
            wait_idle;
            wr(3'h1, {1'b0, r[1:0], 4'h1, r[0]});
            wait_start;
            t1 = t_start;
            wait_start;
            chk("period", 8'(PER[r]), 8'(t_start - t1));
        end
        complete_run;
    end
endmodule // tsr_core_test
`default_nettype wire

/* File: hw/tsr_core.v */
// Temperature sensor register file with conversion and limit control
//
// Contract
// - Selector codes 0..4 pick the five registers
// - High byte holds result bits eleven to four
// - Low byte: result bits three-zero, rest zero
// - Config field layout; resets to mode continuous
// - Rate field picks 0.25, 1, 4, 8 Hz
// - Mode 00 shutdown, 01 one-shot, 1x continuous
// - Shutdown stops conversions, registers stay reachable
// - One-shot from shutdown: one conversion, back
// - Continuous mode converts at selected rate
// - Compare each result against both thresholds
// - Upper flag when high byte above upper
// - Lower flag when high byte below lower
// - Between thresholds clears both flags when latch is off
// - Latch off: flags follow each conversion
// - Latch on: hold until configuration read completes
// - Thresholds reset to plus 60, minus 10
// - Thresholds are read-write signed whole-degree bytes
// - Registers update only on complete bytes
// - Result is 12-bit two's complement, 1/16 degree
// - Temperature reads zero until first conversion
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.vh"

module tsr_core #(
    parameter [31:0] RATE_0P25HZ_CYC = `TSR_PER_0P25HZ_MS * `TSR_CLK_KHZ,
    parameter [31:0] RATE_1HZ_CYC    = `TSR_PER_1HZ_MS * `TSR_CLK_KHZ,
    parameter [31:0] RATE_4HZ_CYC    = `TSR_PER_4HZ_MS * `TSR_CLK_KHZ,
    parameter [31:0] RATE_8HZ_CYC    = `TSR_PER_8HZ_MS * `TSR_CLK_KHZ
) (
    input  wire        clk_i,
    input  wire        rst_i,
    // Byte strobes from the serial engine, one complete byte each
    input  wire        sel_wr_i,
    input  wire [7:0]  sel_data_i,
    input  wire        data_wr_i,
    input  wire [7:0]  wr_data_i,
    input  wire        rd_second_i,
    output wire [7:0]  rd_data_o,
    input  wire        cfg_rd_done_i,
    // Converter handshake
    output wire        conv_start_o,
    input  wire        conv_done_i,
    input  wire [11:0] conv_result_i,
    output wire        conv_busy_o,
    // Comparison indicators mirrored for pins
    output wire        upper_flag_o,
    output wire        lower_flag_o
);

    // Conversion states, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_CONV = 2'b10;

    // Reset image of the configuration byte, sliced for the top and mode fields so widths match
    localparam [7:0] CFG_RST = `TSR_CFG_RESET;

    // Signed byte comparison, used for both limits
    function tsr_gt;
        input [7:0] a;
        input [7:0] b;
        begin
            tsr_gt = ($signed(a) > $signed(b));
        end
    endfunction

    // Continuous when the mode high bit is set
    function tsr_is_cont;
        input [1:0] mode;
        begin
            tsr_is_cont = mode[1];
        end
    endfunction

    // Register state
    reg [2:0]  sel_q;
    reg        top_q;
    reg [1:0]  rate_q;
    reg        latch_q;
    reg [1:0]  mode_q;
    reg        upper_flag_q;
    reg        lower_flag_q;
    reg [7:0]  lower_q;
    reg [7:0]  upper_q;
    reg [11:0] temp_q;
    reg [7:0]  rd_data_q;
    reg [1:0]  state_q;
    reg        start_q;
    reg        oneshot_pend_q;
    reg        oneshot_run_q;
    reg        restart_q;

    // Next values
    reg [1:0]  mode_d;
    reg [1:0]  rate_d;
    reg        upper_flag_d;
    reg        lower_flag_d;
    reg [7:0]  rd_data_d;
    reg [1:0]  state_d;
    reg        start_d;
    reg        oneshot_pend_d;
    reg        oneshot_run_d;
    reg        restart_d;
    reg [31:0] period_sel;

    wire       cfg_wr;
    wire       conv_end;
    wire       tick;
    wire [7:0] new_hi;
    wire       upper_hit;
    wire       lower_hit;
    wire       flag_clr;
    wire [7:0] cfg_byte;

    // Data writes act only on whole bytes from the engine
    assign cfg_wr   = data_wr_i && (sel_q == `TSR_SEL_CFG);
    assign conv_end = (state_q == ST_CONV) && conv_done_i;

    // Result high byte and both limit outcomes
    assign new_hi    = conv_result_i[`TSR_RES_HI_MSB:`TSR_RES_HI_LSB];
    assign upper_hit = tsr_gt(new_hi, upper_q);
    assign lower_hit = tsr_gt(lower_q, new_hi);
    assign flag_clr  = latch_q && cfg_rd_done_i;

    // Configuration byte as read back
    assign cfg_byte = {top_q, rate_q, upper_flag_q, lower_flag_q,
                       latch_q, mode_q};

    // Selector keeps only the three select bits; upper bits are the host's duty
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_q <= `TSR_SEL_TEMP_HI;
        end else if (sel_wr_i) begin
            sel_q <= sel_data_i[`TSR_SEL_MSB:`TSR_SEL_LSB];
        end
    end

    // Threshold registers, writable in whole bytes
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lower_q <= `TSR_LOWER_RESET;
            upper_q <= `TSR_UPPER_RESET;
        end else if (data_wr_i) begin
            if (sel_q == `TSR_SEL_LOWER) begin
                lower_q <= wr_data_i;
            end
            if (sel_q == `TSR_SEL_UPPER) begin
                upper_q <= wr_data_i;
            end
        end
    end

    // Static configuration bits
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            top_q   <= CFG_RST[`TSR_CFG_TOP];
            latch_q <= 1'b0;
        end else if (cfg_wr) begin
            top_q   <= wr_data_i[`TSR_CFG_TOP];
            latch_q <= wr_data_i[`TSR_CFG_LATCH];
        end
    end

    // Mode and rate; a one-shot run drops back to shutdown on its own
    always @* begin
        mode_d = mode_q;
        rate_d = rate_q;
        if (cfg_wr) begin
            // Host write wins over the automatic return
            mode_d = wr_data_i[`TSR_CFG_MODE_HI:`TSR_CFG_MODE_LO];
            rate_d = wr_data_i[`TSR_CFG_RATE_HI:`TSR_CFG_RATE_LO];
        end else if (conv_end && oneshot_run_q) begin
            mode_d = `TSR_MODE_SHUTDOWN;
        end
    end

    // Pacing restarts whenever rate or mode changes
    always @* begin
        restart_d = (rate_d != rate_q) || (mode_d != mode_q);
    end

    // One-shot request only when leaving shutdown with mode 01
    always @* begin
        oneshot_pend_d = oneshot_pend_q;
        if (cfg_wr) begin
            oneshot_pend_d = (mode_q == `TSR_MODE_SHUTDOWN) &&
                (wr_data_i[`TSR_CFG_MODE_HI:`TSR_CFG_MODE_LO] == `TSR_MODE_ONESHOT);
        end else if (start_d) begin
            oneshot_pend_d = 1'b0;
        end
    end

    // Marks the conversion that belongs to a one-shot request
    always @* begin
        oneshot_run_d = oneshot_run_q;
        if (start_d) begin
            oneshot_run_d = oneshot_pend_q;
        end else if (conv_end) begin
            oneshot_run_d = 1'b0;
        end
    end

    // Mode bits and pacing control state
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q         <= CFG_RST[`TSR_CFG_MODE_HI:`TSR_CFG_MODE_LO];
            rate_q         <= `TSR_RATE_0P25HZ;
            restart_q      <= 1'b0;
            oneshot_pend_q <= 1'b0;
            oneshot_run_q  <= 1'b0;
        end else begin
            mode_q         <= mode_d;
            rate_q         <= rate_d;
            restart_q      <= restart_d;
            oneshot_pend_q <= oneshot_pend_d;
            oneshot_run_q  <= oneshot_run_d;
        end
    end

    // Period for the selected rate
    always @* begin
        case (rate_q)
            `TSR_RATE_0P25HZ: period_sel = RATE_0P25HZ_CYC;
            `TSR_RATE_1HZ:    period_sel = RATE_1HZ_CYC;
            `TSR_RATE_4HZ:    period_sel = RATE_4HZ_CYC;
            `TSR_RATE_8HZ:    period_sel = RATE_8HZ_CYC;
            default:          period_sel = RATE_0P25HZ_CYC;
        endcase
    end

    // Timebase only runs in continuous mode
    tsr_rate_timer u_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .run_i     (tsr_is_cont(mode_q)),
        .restart_i (restart_q),
        .period_i  (period_sel),
        .tick_o    (tick)
    );

    // Conversion sequencer; shutdown simply issues no starts
    always @* begin
        state_d = state_q;
        start_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // A tick during a running conversion is dropped, not queued
                if ((tick && tsr_is_cont(mode_q)) || oneshot_pend_q) begin
                    start_d = 1'b1;
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done_i) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer state and start strobe
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            start_q <= start_d;
        end
    end

    // Result register, zero until the first conversion lands
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            temp_q <= `TSR_TEMP_RESET;
        end else if (conv_end) begin
            temp_q <= conv_result_i;
        end
    end

    // Indicators; a new hit wins over a clearing read in the same cycle
    always @* begin
        upper_flag_d = flag_clr ? 1'b0 : upper_flag_q;
        lower_flag_d = flag_clr ? 1'b0 : lower_flag_q;
        if (conv_end) begin
            if (latch_q) begin
                upper_flag_d = upper_flag_d | upper_hit;
                lower_flag_d = lower_flag_d | lower_hit;
            end else begin
                // Neither hit means both clear
                upper_flag_d = upper_hit;
                lower_flag_d = lower_hit;
            end
        end
    end

    // Indicator flip-flops
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            upper_flag_q <= 1'b0;
            lower_flag_q <= 1'b0;
        end else begin
            upper_flag_q <= upper_flag_d;
            lower_flag_q <= lower_flag_d;
        end
    end

    // Read mux; unused selector codes read as zero
    always @* begin
        case (sel_q)
            `TSR_SEL_TEMP_HI: begin
                // Second byte of a temperature read is the low byte
                if (rd_second_i) begin
                    rd_data_d = {temp_q[`TSR_RES_LO_MSB:`TSR_RES_LO_LSB],
                                 `TSR_NIBBLE_ZERO};
                end else begin
                    rd_data_d = temp_q[`TSR_RES_HI_MSB:`TSR_RES_HI_LSB];
                end
            end
            `TSR_SEL_CFG:     rd_data_d = cfg_byte;
            `TSR_SEL_LOWER:   rd_data_d = lower_q;
            `TSR_SEL_UPPER:   rd_data_d = upper_q;
            `TSR_SEL_TEMP_LO: rd_data_d = {temp_q[`TSR_RES_LO_MSB:`TSR_RES_LO_LSB],
                                           `TSR_NIBBLE_ZERO};
            default:          rd_data_d = `TSR_BYTE_ZERO;
        endcase
    end

    // Read data is registered, one cycle behind the selector
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_q <= `TSR_BYTE_ZERO;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    // Outputs
    assign rd_data_o    = rd_data_q;
    assign conv_start_o = start_q;
    assign conv_busy_o  = (state_q == ST_CONV);
    assign upper_flag_o = upper_flag_q;
    assign lower_flag_o = lower_flag_q;

endmodule // tsr_core

`default_nettype wire

/* File: hw/tsr_defines.vh */
// Constants for the temperature sensor register core
`ifndef TSR_DEFINES_VH
`define TSR_DEFINES_VH

// Register selector codes, low three bits of the selector byte
`define TSR_SEL_TEMP_HI     3'h0
`define TSR_SEL_CFG         3'h1
`define TSR_SEL_LOWER       3'h2
`define TSR_SEL_UPPER       3'h3
`define TSR_SEL_TEMP_LO     3'h4
`define TSR_SEL_MSB         2
`define TSR_SEL_LSB         0

// Configuration byte field positions
`define TSR_CFG_TOP         7
`define TSR_CFG_RATE_HI     6
`define TSR_CFG_RATE_LO     5
`define TSR_CFG_UPPER_FLAG  4
`define TSR_CFG_LOWER_FLAG  3
`define TSR_CFG_LATCH       2
`define TSR_CFG_MODE_HI     1
`define TSR_CFG_MODE_LO     0

// Reset values
`define TSR_CFG_RESET       8'h02
`define TSR_UPPER_RESET     8'h3C
`define TSR_LOWER_RESET     8'hF6
`define TSR_TEMP_RESET      12'h000
`define TSR_BYTE_ZERO       8'h00
`define TSR_NIBBLE_ZERO     4'h0
`define TSR_CNT_ZERO        32'h0000_0000
`define TSR_CNT_ONE         32'h0000_0001

// Temperature result layout
`define TSR_RES_HI_MSB      11
`define TSR_RES_HI_LSB      4
`define TSR_RES_LO_MSB      3
`define TSR_RES_LO_LSB      0

// Mode and rate codes
`define TSR_MODE_SHUTDOWN   2'h0
`define TSR_MODE_ONESHOT    2'h1
`define TSR_RATE_0P25HZ     2'h0
`define TSR_RATE_1HZ        2'h1
`define TSR_RATE_4HZ        2'h2
`define TSR_RATE_8HZ        2'h3

// Conversion periods in ms and clock rate in kHz
`define TSR_PER_0P25HZ_MS   4000
`define TSR_PER_1HZ_MS      1000
`define TSR_PER_4HZ_MS      250
`define TSR_PER_8HZ_MS      125
`define TSR_CLK_KHZ         125000

`endif

/* File: hw/tsr_rate_timer.v */
// Conversion pacing timebase for continuous mode
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.vh"

module tsr_rate_timer (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        run_i,
    input  wire        restart_i,
    input  wire [31:0] period_i,
    output wire        tick_o
);

    reg [31:0] count_q;
    reg [31:0] count_d;

    // Down counter; zero means a conversion is due
    always @* begin
        if (!run_i || restart_i) begin
            count_d = `TSR_CNT_ZERO;
        end else if (count_q == `TSR_CNT_ZERO) begin
            count_d = period_i - `TSR_CNT_ONE;
        end else begin
            count_d = count_q - `TSR_CNT_ONE;
        end
    end

    // Counter state
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= `TSR_CNT_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

    // First tick comes right after a restart, then once per period
    assign tick_o = run_i && !restart_i && (count_q == `TSR_CNT_ZERO);

endmodule // tsr_rate_timer

`default_nettype wire
